/* cnc_device.sv */
// Node end: identity objects, Node-ID handling by SDO, LSS and NMT reset.
// What this block does
// R1: 64-bit serial; low half is identity serial.
// R2: Writing low half clears high half.
// R3: Separate 64-bit maintenance timestamp, two halves.
// R4: Boot-up frame on 0x700 plus Node-ID.
// R5: SDO answers on 0x580 plus Node-ID.
// R6: Four-byte upload answered with command 0x43.
// R7: Multi-byte values sent low byte first.
// R8: Node-ID is 1 to 127, unique.
// R9: SDO Node-ID change: no confirm, boot-up instead.
// R10: SDO Node-ID change is volatile until stored.
// R11: LSS Node-ID change keeps the SYNC, TIME, EMCY and TPDO COB-IDs; SDO and boot-up follow the new Node-ID after reset.
// R12: Master talks LSS to one node only.
// R13: Switch-mode-global enters LSS configuration mode.
// R14: LSS inquiry answered with current Node-ID.
// R15: LSS configure answered with error code.
// R16: Store on 0x7E5, answer 0x7E4 with code.
// R17: LSS settings apply at reset, old address.
// R18: Automatic sub-index reloads default COB-IDs.
// R19: Out-of-range Node-ID write aborts, nothing changes.
`timescale 1ns/100ps
module cnc_device #(
  parameter logic [7:0] DEFAULT_NODE_ID = 8'h01
) (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        ce_in,
  cnc_link_if.device       link,
  output logic [7:0]       node_id_out,
  output logic [7:0]       stored_id_out,
  output logic             lss_mode_out,
  output logic [63:0]      serial_out,
  output logic [63:0]      maint_out,
  output logic [31:0]      cob_sync_out,
  output logic [31:0]      cob_time_out,
  output logic [31:0]      cob_emcy_out,
  output logic [31:0]      cob_tpdo1_out,
  output logic [31:0]      cob_tpdo2_out
);
  import cnc_pkg::*;

  // A power-on Node-ID outside the legal range cannot be served.
  if (!id_valid(DEFAULT_NODE_ID)) begin : g_bad_id
    $error("DEFAULT_NODE_ID must lie between 1 and 127");
  end

  typedef struct packed {
    logic [7:0]   node_id;   // Identifier in use now.
    logic [7:0]   cfg_id;    // Identifier taken at the next reset.
    logic [7:0]   stored_id; // Image of the non-volatile copy.
    cnc_lss_e     lss;
    logic         boot_pend;
    logic [31:0]  ser_lo;
    logic [31:0]  ser_hi;
    logic [31:0]  mnt_lo;
    logic [31:0]  mnt_hi;
    logic [31:0]  cob_sync;
    logic [31:0]  cob_time;
    logic [31:0]  cob_emcy;
    logic [31:0]  cob_tpdo1;
    logic [31:0]  cob_tpdo2;
    logic         tx_valid;
    logic [ID_W-1:0]  tx_id;
    logic [DLC_W-1:0] tx_dlc;
    cnc_payload_s tx_data;
  } cnc_dev_state_s;

  localparam cnc_dev_state_s RESET_STATE = '{
    node_id:   DEFAULT_NODE_ID,
    cfg_id:    DEFAULT_NODE_ID,
    stored_id: DEFAULT_NODE_ID,
    lss:       LSS_WAIT,
    boot_pend: 1'b1,
    cob_sync:  DEF_SYNC,
    cob_time:  DEF_TIME,
    cob_emcy:  DEF_EMCY + {24'h00_0000, DEFAULT_NODE_ID},
    cob_tpdo1: DEF_TPDO1 + {24'h00_0000, DEFAULT_NODE_ID},
    cob_tpdo2: DEF_TPDO2 + {24'h00_0000, DEFAULT_NODE_ID},
    tx_id:     COB_NMT,
    default:   '0
  };

  cnc_dev_state_s s;
  cnc_dev_state_s next_s;

  cnc_payload_s   req;
  logic [15:0]    req_idx;
  logic [31:0]    req_val;
  logic           sdo_req;
  logic           lss_req;
  logic           nmt_req;
  logic           is_up;
  logic           is_dn;
  logic [7:0]     rsp_cmd;
  logic [31:0]    rsp_val;
  logic           rsp_send;
  logic           node_wr;
  logic           obj_wr;
  cnc_payload_s   sdo_frame;

  // Request fields; data bytes arrive least significant first.
  assign req     = link.m_data;
  assign req_idx = {req.b2, req.b1};
  assign req_val = {req.b7, req.b6, req.b5, req.b4}; // [R7]
  assign is_up   = req.b0 == SDO_UPLOAD;
  assign is_dn   = (req.b0 == SDO_DN4) || (req.b0 == SDO_DN1);
  assign nmt_req = link.m_valid && (link.m_id == COB_NMT);
  assign lss_req = link.m_valid && (link.m_id == COB_LSS_REQ);
  assign sdo_req = link.m_valid &&
                   (link.m_id == COB_SDO_RX + ID_W'(s.node_id));

  // SDO object decode: answer command, value and which write is legal.
  always_comb begin
    rsp_cmd  = SDO_ABORT;
    rsp_val  = ABORT_NOOBJ;
    rsp_send = 1'b1;
    node_wr  = 1'b0;
    obj_wr   = 1'b0;
    if (!is_up && !is_dn) begin
      rsp_val = ABORT_CMD;
    end else begin
      case (req_idx)
        IDX_SERIAL, IDX_MAINT: begin
          if (req.b3 == SUB_COUNT) begin
            rsp_cmd = is_up ? SDO_UP1 : SDO_ABORT;
            rsp_val = is_up ? OBJ_SUBS : ABORT_RO;
          end else if (req.b3 == SUB_LO || req.b3 == SUB_HI) begin
            obj_wr  = is_dn;
            rsp_cmd = is_up ? SDO_UP4 : SDO_DN_ACK; // [R6]
            if (is_dn)
              rsp_val = '0;
            else if (req_idx == IDX_SERIAL)
              rsp_val = (req.b3 == SUB_LO) ? s.ser_lo : s.ser_hi;
            else
              rsp_val = (req.b3 == SUB_LO) ? s.mnt_lo : s.mnt_hi;
          end else begin
            rsp_val = ABORT_NOSUB;
          end
        end
        IDX_NODE: begin
          if (req.b3 == SUB_COUNT) begin
            rsp_cmd = is_up ? SDO_UP1 : SDO_ABORT;
            rsp_val = is_up ? OBJ_SUBS : ABORT_RO;
          end else if (req.b3 == SUB_PLAIN || req.b3 == SUB_AUTO) begin
            if (is_up) begin
              rsp_cmd = SDO_UP1;
              rsp_val = {24'h00_0000, s.node_id};
            end else if (id_valid(req.b4)) begin // [R8]
              node_wr  = 1'b1;
              rsp_send = 1'b0; // [R9]
            end else begin
              rsp_val = ABORT_RANGE; // [R19]
            end
          end else begin
            rsp_val = ABORT_NOSUB;
          end
        end
        IDX_IDENT: begin
          if (req.b3 == SUB_SERNO) begin
            rsp_cmd = is_up ? SDO_UP4 : SDO_ABORT; // [R6]
            rsp_val = is_up ? s.ser_lo : ABORT_RO; // [R1]
          end else begin
            rsp_val = ABORT_NOSUB;
          end
        end
        default: begin
          rsp_val = ABORT_NOOBJ;
        end
      endcase
    end
  end

  cnc_sdo_pack u_pack (
    .cmd_in   (rsp_cmd),
    .index_in (req_idx),
    .sub_in   (req.b3),
    .value_in (rsp_val),
    .frame_out(sdo_frame)
  );

  // Next state. One frame leaves per cycle; a request in the same cycle
  // as a pending boot-up wins, and the boot-up goes out on the next free
  // cycle, so a master flooding the node can delay it.
  always_comb begin
    logic lss_open;
    lss_open = 1'b0;
    next_s = s;
    next_s.tx_valid = 1'b0;
    case (s.lss)
      LSS_CONFIG: lss_open = 1'b1;
      default:    lss_open = 1'b0;
    endcase
    if (nmt_req) begin
      if ((req.b0 == NMT_RESET_NODE || req.b0 == NMT_RESET_COMM) &&
          (req.b1 == NMT_ALL || req.b1 == s.node_id)) begin
        next_s.node_id   = s.cfg_id; // [R17]
        next_s.lss       = LSS_WAIT;
        next_s.boot_pend = 1'b1;
      end
    end else if (sdo_req) begin
      if (obj_wr) begin
        if (req_idx == IDX_SERIAL && req.b3 == SUB_LO) begin
          next_s.ser_lo = req_val; // [R1]
          next_s.ser_hi = '0; // [R2]
        end else if (req_idx == IDX_SERIAL) begin
          next_s.ser_hi = req_val;
        end else if (req.b3 == SUB_LO) begin
          next_s.mnt_lo = req_val; // [R3]
          next_s.mnt_hi = '0; // [R2]
        end else begin
          next_s.mnt_hi = req_val; // [R3]
        end
      end
      if (node_wr) begin
        // Only the volatile identifiers change; stored_id is untouched.
        next_s.node_id   = req.b4; // [R10]
        next_s.cfg_id    = req.b4;
        next_s.boot_pend = 1'b1; // [R9]
        if (req.b3 == SUB_AUTO) begin
          next_s.cob_sync  = (s.cob_sync & COB_KEEP) | DEF_SYNC; // [R18]
          next_s.cob_time  = (s.cob_time & COB_KEEP) | DEF_TIME;
          next_s.cob_emcy  = (s.cob_emcy & COB_KEEP) |
                             (DEF_EMCY + {24'h00_0000, req.b4});
          next_s.cob_tpdo1 = (s.cob_tpdo1 & COB_KEEP) |
                             (DEF_TPDO1 + {24'h00_0000, req.b4});
          next_s.cob_tpdo2 = (s.cob_tpdo2 & COB_KEEP) |
                             (DEF_TPDO2 + {24'h00_0000, req.b4});
        end
      end
      if (rsp_send) begin
        next_s.tx_valid = 1'b1;
        next_s.tx_id    = COB_SDO_TX + ID_W'(s.node_id); // [R5]
        next_s.tx_dlc   = DLC_FULL;
        next_s.tx_data  = sdo_frame;
      end
    end else if (lss_req) begin
      next_s.tx_id   = COB_LSS_RSP;
      next_s.tx_dlc  = DLC_FULL;
      next_s.tx_data = '0;
      next_s.tx_data.b0 = req.b0;
      if (req.b0 == LSS_CS_SWITCH) begin
        next_s.lss = (req.b1 == LSS_MODE_CFG) ? LSS_CONFIG : LSS_WAIT; // [R13]
      end else if (lss_open && req.b0 == LSS_CS_CFG_ID) begin
        // Only the pending identifier moves; COB-IDs stay as they are.
        next_s.tx_valid = 1'b1; // [R11]
        if (id_valid(req.b1)) begin
          next_s.cfg_id     = req.b1;
          next_s.tx_data.b1 = LSS_ERR_OK; // [R15]
        end else begin
          next_s.tx_data.b1 = LSS_ERR_RANGE; // [R15]
        end
      end else if (lss_open && req.b0 == LSS_CS_STORE) begin
        next_s.stored_id  = s.cfg_id; // [R16]
        next_s.tx_valid   = 1'b1;
        next_s.tx_data.b1 = LSS_ERR_OK;
      end else if (lss_open && req.b0 == LSS_CS_INQ_ID) begin
        next_s.tx_valid   = 1'b1; // [R14]
        next_s.tx_data.b1 = s.node_id;
      end
    end else if (s.boot_pend) begin
      next_s.boot_pend = 1'b0;
      next_s.tx_valid  = 1'b1;
      next_s.tx_id     = COB_BOOT + ID_W'(s.node_id); // [R4]
      next_s.tx_dlc    = DLC_BOOT;
      next_s.tx_data   = '0;
    end
  end

  // State register; the clock enable freezes everything.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s <= RESET_STATE;
    end else if (ce_in) begin
      s <= next_s;
    end
  end

  // Outputs straight from the state register.
  assign link.d_valid  = s.tx_valid;
  assign link.d_id     = s.tx_id;
  assign link.d_dlc    = s.tx_dlc;
  assign link.d_data   = s.tx_data;
  assign node_id_out   = s.node_id;
  assign stored_id_out = s.stored_id;
  assign lss_mode_out  = s.lss == LSS_CONFIG;
  assign serial_out    = {s.ser_hi, s.ser_lo};
  assign maint_out     = {s.mnt_hi, s.mnt_lo};
  assign cob_sync_out  = s.cob_sync;
  assign cob_time_out  = s.cob_time;
  assign cob_emcy_out  = s.cob_emcy;
  assign cob_tpdo1_out = s.cob_tpdo1;
  assign cob_tpdo2_out = s.cob_tpdo2;
endmodule : cnc_device

/* cnc_pkg.sv */
// Shared constants, types and helpers for the CANopen node configuration link.
package cnc_pkg;

  // Frame geometry.
  localparam int ID_W   = 11;
  localparam int DLC_W  = 4;
  localparam int WORD_W = 32;
  localparam int ADDR_W = 4;

  // Eight data bytes; b0 is the first byte on the wire.
  typedef struct packed {
    logic [7:0] b7;
    logic [7:0] b6;
    logic [7:0] b5;
    logic [7:0] b4;
    logic [7:0] b3;
    logic [7:0] b2;
    logic [7:0] b1;
    logic [7:0] b0;
  } cnc_payload_s;

  // LSS slave states, one-hot.
  typedef enum logic [1:0] {
    LSS_WAIT   = 2'b01,
    LSS_CONFIG = 2'b10
  } cnc_lss_e;

  // CAN identifiers and bases.
  localparam logic [ID_W-1:0] COB_NMT      = 11'h000;
  localparam logic [ID_W-1:0] COB_BOOT     = 11'h700;
  localparam logic [ID_W-1:0] COB_SDO_TX   = 11'h580;
  localparam logic [ID_W-1:0] COB_SDO_RX   = 11'h600;
  localparam logic [ID_W-1:0] COB_LSS_REQ  = 11'h7E5;
  localparam logic [ID_W-1:0] COB_LSS_RSP  = 11'h7E4;
  localparam logic [DLC_W-1:0] DLC_BOOT    = 4'h1;
  localparam logic [DLC_W-1:0] DLC_FULL    = 4'h8;

  // NMT commands.
  localparam logic [7:0] NMT_RESET_NODE = 8'h81;
  localparam logic [7:0] NMT_RESET_COMM = 8'h82;
  localparam logic [7:0] NMT_ALL        = 8'h00;

  // SDO command bytes and abort codes.
  localparam logic [7:0]  SDO_UPLOAD  = 8'h40;
  localparam logic [7:0]  SDO_UP4     = 8'h43;
  localparam logic [7:0]  SDO_UP1     = 8'h4F;
  localparam logic [7:0]  SDO_DN4     = 8'h23;
  localparam logic [7:0]  SDO_DN1     = 8'h2F;
  localparam logic [7:0]  SDO_DN_ACK  = 8'h60;
  localparam logic [7:0]  SDO_ABORT   = 8'h80;
  localparam logic [31:0] ABORT_CMD   = 32'h0504_0001;
  localparam logic [31:0] ABORT_RO    = 32'h0601_0002;
  localparam logic [31:0] ABORT_NOOBJ = 32'h0602_0000;
  localparam logic [31:0] ABORT_NOSUB = 32'h0609_0011;
  localparam logic [31:0] ABORT_RANGE = 32'h0609_0030;

  // Object indices and sub-indices.
  localparam logic [15:0] IDX_IDENT  = 16'h1018;
  localparam logic [15:0] IDX_NODE   = 16'h4001;
  localparam logic [15:0] IDX_SERIAL = 16'h4030;
  localparam logic [15:0] IDX_MAINT  = 16'h4031;
  localparam logic [7:0]  SUB_COUNT  = 8'h00;
  localparam logic [7:0]  SUB_LO     = 8'h01;
  localparam logic [7:0]  SUB_HI     = 8'h02;
  localparam logic [7:0]  SUB_PLAIN  = 8'h01;
  localparam logic [7:0]  SUB_AUTO   = 8'h02;
  localparam logic [7:0]  SUB_SERNO  = 8'h04;
  localparam logic [31:0] OBJ_SUBS   = 32'h0000_0002;

  // LSS command specifiers, modes and error codes.
  localparam logic [7:0] LSS_CS_SWITCH = 8'h04;
  localparam logic [7:0] LSS_CS_CFG_ID = 8'h11;
  localparam logic [7:0] LSS_CS_STORE  = 8'h17;
  localparam logic [7:0] LSS_CS_INQ_ID = 8'h5E;
  localparam logic [7:0] LSS_MODE_CFG  = 8'h01;
  localparam logic [7:0] LSS_ERR_OK    = 8'h00;
  localparam logic [7:0] LSS_ERR_RANGE = 8'h01;

  // Node-ID range and default COB-IDs.
  localparam logic [7:0]  NODE_MIN  = 8'h01;
  localparam logic [7:0]  NODE_MAX  = 8'h7F;
  localparam logic [31:0] COB_KEEP  = 32'hC000_0000;
  localparam logic [31:0] DEF_SYNC  = 32'h0000_0080;
  localparam logic [31:0] DEF_TIME  = 32'h0000_0100;
  localparam logic [31:0] DEF_EMCY  = 32'h0000_0080;
  localparam logic [31:0] DEF_TPDO1 = 32'h0000_0180;
  localparam logic [31:0] DEF_TPDO2 = 32'h0000_0280;

  // Host register map (word addresses).
  localparam logic [ADDR_W-1:0] A_TX_ID  = 4'h0;
  localparam logic [ADDR_W-1:0] A_TX_DLC = 4'h1;
  localparam logic [ADDR_W-1:0] A_TX_LO  = 4'h2;
  localparam logic [ADDR_W-1:0] A_TX_HI  = 4'h3;
  localparam logic [ADDR_W-1:0] A_CTRL   = 4'h4;
  localparam logic [ADDR_W-1:0] A_STATUS = 4'h5;
  localparam logic [ADDR_W-1:0] A_RX_ID  = 4'h6;
  localparam logic [ADDR_W-1:0] A_RX_DLC = 4'h7;
  localparam logic [ADDR_W-1:0] A_RX_LO  = 4'h8;
  localparam logic [ADDR_W-1:0] A_RX_HI  = 4'h9;
  localparam int CTRL_SEND  = 0;
  localparam int ST_RX      = 0;
  localparam int ST_OVR     = 1;
  localparam int ST_REFUSED = 2;
  localparam int ST_LSS     = 3;

  // True for a Node-ID the network may use.
  function automatic logic id_valid(input logic [7:0] v);
    return (v >= NODE_MIN) && (v <= NODE_MAX);
  endfunction : id_valid

endpackage : cnc_pkg

/* cnc_link_if.sv */
// Frame-level CAN link between the configuration master and the node.
`timescale 1ns/100ps
interface cnc_link_if;
  // Master to node: one-cycle frame strobe with identifier and data.
  logic                         m_valid;
  logic [cnc_pkg::ID_W-1:0]     m_id;
  logic [cnc_pkg::DLC_W-1:0]    m_dlc;
  cnc_pkg::cnc_payload_s        m_data;
  // Node to master: same shape.
  logic                         d_valid;
  logic [cnc_pkg::ID_W-1:0]     d_id;
  logic [cnc_pkg::DLC_W-1:0]    d_dlc;
  cnc_pkg::cnc_payload_s        d_data;

  modport device (input  m_valid, m_id, m_dlc, m_data,
                  output d_valid, d_id, d_dlc, d_data);
  modport host   (output m_valid, m_id, m_dlc, m_data,
                  input  d_valid, d_id, d_dlc, d_data);
endinterface : cnc_link_if

/* cnc_sdo_pack.sv */
// Packs an expedited SDO answer, low byte first, into a frame payload.
`timescale 1ns/100ps
module cnc_sdo_pack (
  input  wire logic [7:0]            cmd_in,
  input  wire logic [15:0]           index_in,
  input  wire logic [7:0]            sub_in,
  input  wire logic [31:0]           value_in,
  output cnc_pkg::cnc_payload_s      frame_out
);
  import cnc_pkg::*;

  // Concatenation order puts index and value least significant byte first.
  assign frame_out = {value_in, sub_in, index_in, cmd_in}; // [R7]
endmodule : cnc_sdo_pack

/* cnc_host.sv */
// Master end: register-driven frame sender and receiver with LSS guards.
`timescale 1ns/100ps
module cnc_host (
  input  wire logic                          clk_in,
  input  wire logic                          rst_n_in,
  input  wire logic                          ce_in,
  input  wire logic [cnc_pkg::ADDR_W-1:0]    addr_in,
  input  wire logic [cnc_pkg::WORD_W-1:0]    wdata_in,
  input  wire logic                          wr_in,
  input  wire logic                          rd_in,
  output logic [cnc_pkg::WORD_W-1:0]         rdata_out,
  cnc_link_if.host                           link
);
  import cnc_pkg::*;

  typedef struct packed {
    logic [ID_W-1:0]   tx_id;
    logic [DLC_W-1:0]  tx_dlc;
    logic [31:0]       tx_lo;
    logic [31:0]       tx_hi;
    logic              lss_cfg;  // Node believed to be in LSS mode.
    logic              m_valid;
    logic [ID_W-1:0]   m_id;
    logic [DLC_W-1:0]  m_dlc;
    cnc_payload_s      m_data;
    logic [ID_W-1:0]   rx_id;
    logic [DLC_W-1:0]  rx_dlc;
    logic [31:0]       rx_lo;
    logic [31:0]       rx_hi;
    logic              rx_flag;
    logic              rx_ovr;
    logic              refused;
    logic [WORD_W-1:0] rdata;
  } cnc_host_state_s;

  cnc_host_state_s s;
  cnc_host_state_s next_s;
  cnc_payload_s    txp;

  assign txp = {s.tx_hi, s.tx_lo};

  // Register writes, frame launch, capture and reads. The RX, overrun and
  // refused status bits are cleared by writing ones; capture comes after, so a new frame wins.
  always_comb begin
    logic ok;
    ok = 1'b1;
    next_s = s;
    next_s.m_valid = 1'b0;
    next_s.rdata = '0;
    if (wr_in) begin
      case (addr_in)
        A_TX_ID:  next_s.tx_id  = wdata_in[ID_W-1:0];
        A_TX_DLC: next_s.tx_dlc = wdata_in[DLC_W-1:0];
        A_TX_LO:  next_s.tx_lo  = wdata_in;
        A_TX_HI:  next_s.tx_hi  = wdata_in;
        A_STATUS: begin
          if (wdata_in[ST_RX])      next_s.rx_flag = 1'b0;
          if (wdata_in[ST_OVR])     next_s.rx_ovr  = 1'b0;
          if (wdata_in[ST_REFUSED]) next_s.refused = 1'b0;
        end
        A_CTRL: begin
          if (wdata_in[CTRL_SEND]) begin
            if (s.tx_id == COB_LSS_REQ) begin
              if (txp.b0 == LSS_CS_SWITCH)
                next_s.lss_cfg = txp.b1 == LSS_MODE_CFG; // [R13]
              else if (!s.lss_cfg)
                ok = 1'b0; // [R12]
              if (txp.b0 == LSS_CS_CFG_ID && !id_valid(txp.b1))
                ok = 1'b0; // [R8]
            end else if (s.tx_id == COB_NMT &&
                         (txp.b0 == NMT_RESET_NODE ||
                          txp.b0 == NMT_RESET_COMM)) begin
              next_s.lss_cfg = 1'b0; // [R17]
            end
            if (ok) begin
              next_s.m_valid = 1'b1;
              next_s.m_id    = s.tx_id;
              next_s.m_dlc   = s.tx_dlc;
              next_s.m_data  = txp;
            end else begin
              next_s.refused = 1'b1;
            end
          end
        end
        default: ;
      endcase
    end
    if (link.d_valid) begin
      next_s.rx_ovr  = next_s.rx_ovr | s.rx_flag;
      next_s.rx_flag = 1'b1;
      next_s.rx_id   = link.d_id;
      next_s.rx_dlc  = link.d_dlc;
      // Byte 0 lands in the low byte of rx_lo, keeping wire order.
      {next_s.rx_hi, next_s.rx_lo} = link.d_data; // [R7]
    end
    if (rd_in) begin
      case (addr_in)
        A_TX_ID:  next_s.rdata = WORD_W'(s.tx_id);
        A_TX_DLC: next_s.rdata = WORD_W'(s.tx_dlc);
        A_TX_LO:  next_s.rdata = s.tx_lo;
        A_TX_HI:  next_s.rdata = s.tx_hi;
        A_STATUS: begin
          next_s.rdata[ST_RX]      = s.rx_flag;
          next_s.rdata[ST_OVR]     = s.rx_ovr;
          next_s.rdata[ST_REFUSED] = s.refused;
          next_s.rdata[ST_LSS]     = s.lss_cfg;
        end
        A_RX_ID:  next_s.rdata = WORD_W'(s.rx_id);
        A_RX_DLC: next_s.rdata = WORD_W'(s.rx_dlc);
        A_RX_LO:  next_s.rdata = s.rx_lo;
        A_RX_HI:  next_s.rdata = s.rx_hi;
        default:  next_s.rdata = '0;
      endcase
    end
  end

  // State register; the clock enable freezes everything.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s <= '0;
    end else if (ce_in) begin
      s <= next_s;
    end
  end

  assign rdata_out    = s.rdata;
  assign link.m_valid = s.m_valid;
  assign link.m_id    = s.m_id;
  assign link.m_dlc   = s.m_dlc;
  assign link.m_data  = s.m_data;
endmodule : cnc_host

/* cnc_link_sva.sv */
// Checker of frame exchanges between the master and node ends.
`timescale 1ns/100ps
module cnc_link_sva (
  input wire logic                      clk_in,
  input wire logic                      rst_n_in,
  input wire logic                      m_valid,
  input wire logic [cnc_pkg::ID_W-1:0]  m_id,
  input wire logic [cnc_pkg::DLC_W-1:0] m_dlc,
  input wire cnc_pkg::cnc_payload_s     m_data,
  input wire logic                      d_valid,
  input wire logic [cnc_pkg::ID_W-1:0]  d_id,
  input wire logic [cnc_pkg::DLC_W-1:0] d_dlc,
  input wire cnc_pkg::cnc_payload_s     d_data
);
  import cnc_pkg::*;
  logic [10:0] nid;
  logic        cfg;
  // Request decodes; the Node-ID is learnt, since no port carries it.
  wire        lss = m_valid && m_id == COB_LSS_REQ;
  wire        sdo = m_valid && m_id == COB_SDO_RX + nid;
  wire [15:0] idx = {m_data.b2, m_data.b1};
  wire        dn  = m_data.b0 == SDO_DN1 || m_data.b0 == SDO_DN4;
  wire        ok4 = m_data.b4 != 8'h00 && !m_data.b4[7];
  wire        ok1 = m_data.b1 != 8'h00 && !m_data.b1[7];
  // Node-ID follows boot-up frames; the mode follows switch and NMT frames.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      nid <= 11'h000;
      cfg <= 1'b0;
    end else begin
      if (d_valid && d_id[10:7] == 4'hE) nid <= {4'h0, d_id[6:0]};
      if (lss && m_data.b0 == LSS_CS_SWITCH) cfg <= m_data.b1 == 8'h01;
      else if (m_valid && m_id == COB_NMT) cfg <= 1'b0;
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_boot;
    d_valid && d_id[10:7] == 4'hE && d_dlc == DLC_BOOT;
  endsequence
  sequence s_lss(logic [7:0] cs, logic [7:0] b1);
    d_valid && d_id == COB_LSS_RSP && d_data.b0 == cs && d_data.b1 == b1;
  endsequence
  chk_boot_start: assert property (
    $rose(rst_n_in) |-> ##[1:2] s_boot) else $error("no boot-up");
  chk_sdo_reply: assert property (
    sdo && m_data.b0 == SDO_UPLOAD |-> ##1 d_valid && d_id == COB_SDO_TX + nid)
    else $error("bad SDO answer id");
  chk_up4_cmd: assert property (
    sdo && m_data.b0 == SDO_UPLOAD && idx == IDX_SERIAL
    |-> ##1 d_data.b0 == SDO_UP4 && {d_data.b2, d_data.b1} == IDX_SERIAL)
    else $error("bad upload header");
  chk_id_abort: assert property (
    sdo && dn && idx == IDX_NODE && !ok4 |-> ##1 d_valid
    && d_data.b0 == SDO_ABORT && d_data[63:32] == ABORT_RANGE)
    else $error("no range abort");
  chk_id_boot: assert property (
    sdo && dn && idx == IDX_NODE && ok4 |-> ##1 !d_valid ##1 s_boot
    ##0 d_id[7:0] == $past(m_data.b4, 2)) else $error("no boot on new id");
  chk_switch_quiet: assert property (
    lss && m_data.b0 == LSS_CS_SWITCH |-> ##1 !d_valid)
    else $error("answer to switch");
  chk_inq_id: assert property (
    lss && cfg && m_data.b0 == LSS_CS_INQ_ID |-> ##1
    s_lss(LSS_CS_INQ_ID, nid[7:0])) else $error("bad inquiry answer");
  chk_cfg_ok: assert property (
    lss && cfg && m_data.b0 == LSS_CS_CFG_ID && ok1 |-> ##1
    s_lss(LSS_CS_CFG_ID, LSS_ERR_OK)) else $error("bad configure answer");
  chk_store_ok: assert property (
    lss && cfg && m_data.b0 == LSS_CS_STORE |-> ##1
    s_lss(LSS_CS_STORE, LSS_ERR_OK)) else $error("bad store answer");
  chk_nmt_boot: assert property (
    m_valid && m_id == COB_NMT && m_data.b0 == NMT_RESET_NODE
    && m_data.b1 == nid[7:0] |-> ##[1:2] s_boot) else $error("no reboot");
endmodule : cnc_link_sva

/* tb.sv */
// Self-checking bench joining the master end and the node end.
`timescale 1ns/100ps
module tb;
  import cnc_pkg::*;
  logic        clk_in, rst_n_in, wr, rd, lmode;
  logic [3:0]  addr;
  logic [31:0] wdata, rdata, s, a, b, c, emcy;
  logic [10:0] node;
  logic [7:0]  sid, nid;
  int          failures, tests_run, cyc;
  cnc_link_if link ();
  cnc_host cnc_host_inst (.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(1'b1),
    .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
    .rdata_out(rdata), .link(link));
  cnc_device #(.DEFAULT_NODE_ID(8'h01)) cnc_device_inst (.clk_in(clk_in),
    .rst_n_in(rst_n_in), .ce_in(1'b1), .link(link), .node_id_out(nid),
    .stored_id_out(sid), .lss_mode_out(lmode), .serial_out(),
    .maint_out(), .cob_sync_out(), .cob_time_out(), .cob_emcy_out(emcy),
    .cob_tpdo1_out(), .cob_tpdo2_out());
  cnc_link_sva cnc_link_sva_inst (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .m_valid(link.m_valid), .m_id(link.m_id), .m_dlc(link.m_dlc),
    .m_data(link.m_data), .d_valid(link.d_valid), .d_id(link.d_id),
    .d_dlc(link.d_dlc), .d_data(link.d_data));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr_reg(input logic [3:0] ad, input logic [31:0] d);
    @(posedge clk_in);
    wr <= 1'b1;
    addr <= ad;
    wdata <= d;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [3:0] ad, output logic [31:0] d);
    @(posedge clk_in);
    rd <= 1'b1;
    addr <= ad;
    @(posedge clk_in);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg
  task automatic send(input logic [10:0] id, input logic [31:0] lo, hi);
    wr_reg(A_TX_ID, {21'h0, id});
    wr_reg(A_TX_DLC, 32'h8);
    wr_reg(A_TX_LO, lo);
    wr_reg(A_TX_HI, hi);
    wr_reg(A_CTRL, 32'h1);
  endtask : send
  task automatic await(output logic [31:0] rid, rlo, rhi);
    s = 32'h0;
    for (int i = 0; i < 40 && s[0] !== 1'b1; i++) rd_reg(A_STATUS, s);
    check(s & 32'h1, 32'h1);
    rd_reg(A_RX_ID, rid);
    rd_reg(A_RX_LO, rlo);
    rd_reg(A_RX_HI, rhi);
    wr_reg(A_STATUS, 32'h7);
  endtask : await
  task automatic xfer(input logic [10:0] id, eid, input logic [31:0] lo, hi,
                      elo, ehi);
    send(id, lo, hi);
    await(a, b, c);
    check(a, {21'h0, eid});
    check(b, elo);
    check(c, ehi);
  endtask : xfer
  task automatic sdo(input logic [31:0] lo, hi, elo, ehi);
    xfer(COB_SDO_RX + node, COB_SDO_TX + node, lo, hi, elo, ehi);
  endtask : sdo
  task automatic t_objects;
    sdo(32'h01403023, 32'hA1B2C3D4, 32'h01403060, 0);
    sdo(32'h02403023, 32'h55667788, 32'h02403060, 0);
    sdo(32'h02403040, 0, 32'h02403043, 32'h55667788);
    sdo(32'h01403023, 32'hA1B2C3D4, 32'h01403060, 0);
    sdo(32'h02403040, 0, 32'h02403043, 32'h0);
    sdo(32'h01403040, 0, 32'h01403043, 32'hA1B2C3D4);
    sdo(32'h04101840, 0, 32'h04101843, 32'hA1B2C3D4);
    sdo(32'h02403123, 32'h0000ABCD, 32'h02403160, 0);
    sdo(32'h01403123, 32'h12345678, 32'h01403160, 0);
    sdo(32'h02403140, 0, 32'h02403143, 32'h0);
  endtask : t_objects
  task automatic t_node;
    sdo(32'h0140012F, 32'h80, 32'h01400180, ABORT_RANGE);
    send(COB_SDO_RX + node, 32'h0140012F, 32'h05);
    await(a, b, c);
    check(a, 32'h705);
    check(sid, 32'h01);
    check(emcy, 32'h81);
    node = 11'h005;
    send(COB_SDO_RX + node, 32'h0240012F, 32'h06);
    await(a, b, c);
    check(a, 32'h706);
    check(emcy, 32'h86);
  endtask : t_node
  task automatic t_lss;
    send(COB_LSS_REQ, 32'h0104, 0);
    rd_reg(A_STATUS, s);
    check(lmode, 32'h1);
    check(s, 32'h8);
    xfer(COB_LSS_REQ, COB_LSS_RSP, 32'h5E, 0, 32'h065E, 0);
    xfer(COB_LSS_REQ, COB_LSS_RSP, 32'h0911, 0, 32'h11, 0);
    xfer(COB_LSS_REQ, COB_LSS_RSP, 32'h17, 0, 32'h17, 0);
    check(sid, 32'h09);
    check(emcy, 32'h86);
    check(nid, 32'h06);
    send(COB_NMT, 32'h0681, 0);
    await(a, b, c);
    check(a, 32'h709);
    check(nid, 32'h09);
    send(COB_LSS_REQ, 32'h5E, 0);
    rd_reg(A_STATUS, s);
    check(s, 32'h4);
  endtask : t_lss
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : stop_test
  // Free-running clock at 20 MHz.
  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  // A hang is cut short well above the few hundred cycles the run needs.
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      stop_test();
    end
  end
  // Main sequence: reset, boot-up frame, then the scenarios in order.
  initial begin
    {rst_n_in, wr, rd, addr, wdata, failures, tests_run, cyc} = '0;
    node = 11'h001;
    repeat (20) @(posedge clk_in);
    rst_n_in <= 1'b1;
    await(a, b, c);
    check(a, 32'h701);
    t_objects();
    t_node();
    t_lss();
    stop_test();
  end
endmodule : tb
